// ===== rtl/hbp_port_regs.vh
`ifndef HBP_PORT_REGS_VH
`define HBP_PORT_REGS_VH

// Width of the multiplexed address/data bus
`define HBP_BUS_W          8
// Bus style codes held in the style flag
`define HBP_STYLE_DIR      1'b0
`define HBP_STYLE_SEP      1'b1
// Reset value of the style flag
`define HBP_STYLE_RST      `HBP_STYLE_DIR
// Function select codes of the shared request pin
`define HBP_FUNC_IRQ       1'b0
`define HBP_FUNC_NDA       1'b1
// Address of the HDLC interrupt status register; a read clears the request
`define HBP_ISR_ADDR       8'h04
// Consecutive marks that make a line reset
`define HBP_MARKS_RESET    8'h80
`define HBP_MARK_CNT_W     8
`define HBP_MARK_CNT_RST   8'h00
`define HBP_MARK_CNT_ONE   8'h01
// Transfer state codes
`define HBP_ST_W           2
`define HBP_ST_IDLE        2'h0
`define HBP_ST_WR          2'h1
`define HBP_ST_RD          2'h2
// Bus reset values
`define HBP_BYTE_RST       8'h00

`endif

// ===== rtl/hbp_edge.v
`timescale 1ns/1ps
// Registers one strobe and flags its edges in the same cycle the pin moves
module hbp_edge #(
  parameter RST_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire i_mclk,
  input  wire i_sys_rst,
  // Pin level, already synchronous
  input  wire i_level,
  // Edge flags and the stored level
  output wire o_rise,
  output wire o_fall,
  output wire o_prev
);

  reg prev_q;                     // Level seen on the previous edge

  // Previous level, reset to the idle level of the pin
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      prev_q <= RST_LEVEL;
    end else begin
      prev_q <= i_level;
    end
  end

  // Edges compare the pin against the stored level
  assign o_rise = i_level & ~prev_q;
  assign o_fall = ~i_level & prev_q;
  assign o_prev = prev_q;

endmodule // hbp_edge

// ===== rtl/hbp_port.v
// Overview of operation
// [R1] Direction high reads, low writes
// [R2] Separate style: direction pin is write strobe
// [R3] Direction style: high data strobe qualifies transfer
// [R4] Separate style: read strobe makes device drive
// [R5] Direction style: address taken at strobe fall
// [R6] Respond only while device select low
// [R7] Interrupt held until status register read
// [R8] Control bit picks interrupt or new-data
// [R9] New-data function pulls shared pin low
// [R10] Read strobe level at latch rise picks style
// [R11] Reset forces direction-strobe style
// [R12] Reset restores defaults, clears HDLC, FIFOs
// [R13] Terminal mode: 128 marks pull reset low
// [R14] Network mode: line pin carries receive data
// [R15] Separate style: address taken at latch fall
`timescale 1ns/1ps
`include "hbp_port_regs.vh"
module hbp_port (
  // Clock and reset
  input  wire                      i_mclk,
  input  wire                      i_sys_rst,
  // Host bus strobes
  input  wire                      i_rw_wr,
  input  wire                      i_transfer_strobe,
  input  wire                      i_addr_capture_strobe,
  input  wire                      i_dev_sel_n,
  // Multiplexed bus pins
  input  wire [`HBP_BUS_W-1:0]     i_muxed_bus,
  output wire [`HBP_BUS_W-1:0]     o_muxed_bus,
  output wire                      o_muxed_bus_oe,
  // Internal register side
  output wire [`HBP_BUS_W-1:0]     o_reg_addr,
  output wire [`HBP_BUS_W-1:0]     o_wr_data,
  output wire                      o_wr_pulse,
  output wire                      o_rd_pulse,
  input  wire [`HBP_BUS_W-1:0]     i_rd_data,
  // Shared request pin and its sources
  input  wire                      i_irq_pin_function_select,
  input  wire                      i_hdlc_irq,
  input  wire                      i_new_rx_data,
  output wire                      o_irq_nda,
  output wire                      o_irq_nda_oe,
  // Line reset / star pin and its sources
  input  wire                      i_te_mode,
  input  wire                      i_rx_bit_valid,
  input  wire                      i_rx_mark,
  input  wire                      i_star_bit_en,
  input  wire                      i_star_rx_data,
  output wire                      o_line_rst_star,
  output wire                      o_line_rst_star_oe,
  // Status towards the rest of the device
  output wire                      o_bus_style,
  output wire                      o_core_rst
);

  // Transfer states
  localparam [`HBP_ST_W-1:0] ST_IDLE = `HBP_ST_IDLE;
  localparam [`HBP_ST_W-1:0] ST_WR   = `HBP_ST_WR;
  localparam [`HBP_ST_W-1:0] ST_RD   = `HBP_ST_RD;

  // Registered state
  reg [`HBP_ST_W-1:0]       state_q;       // Transfer state
  reg [`HBP_ST_W-1:0]       state_d;
  reg                       style_q;       // Bus style flag
  reg [`HBP_BUS_W-1:0]      addr_q;        // Captured register address
  reg [`HBP_BUS_W-1:0]      wr_data_q;     // Last write byte seen
  reg [`HBP_BUS_W-1:0]      wr_data_d;
  reg                       wr_pulse_q;    // One-cycle write request
  reg                       wr_pulse_d;
  reg                       rd_pulse_q;    // One-cycle read request
  reg                       rd_pulse_d;
  reg [`HBP_BUS_W-1:0]      bus_out_q;     // Read byte on the pins
  reg                       bus_oe_q;      // Pin drive enable
  reg                       irq_pend_q;    // Sticky HDLC request
  reg                       irq_oe_q;      // Shared pin pulled low
  reg                       irq_out_q;     // Open drain: always drives low
  reg [`HBP_MARK_CNT_W-1:0] mark_cnt_q;    // Consecutive marks, saturating
  reg                       line_oe_q;     // Line pin pulled low
  reg                       line_out_q;    // Open drain: always drives low
  reg                       core_rst_q;    // Reset to HDLC and control logic

  // Edge flags of the two strobes that need them, then select, status read and mark limit
  wire as_rise;
  wire as_fall;
  wire ds_rise;
  wire selected;
  wire isr_read;
  wire marks_full;

  // Address latch strobe idles low in both styles
  hbp_edge #(
    .RST_LEVEL (1'b0)
  ) u_as_edge (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_addr_capture_strobe),
    .o_rise    (as_rise),
    .o_fall    (as_fall),
    .o_prev    ()
  );

  // Data strobe edge; only the rise matters in direction style
  hbp_edge #(
    .RST_LEVEL (1'b0)
  ) u_ds_edge (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_level   (i_transfer_strobe),
    .o_rise    (ds_rise),
    .o_fall    (),
    .o_prev    ()
  );

  assign selected   = ~i_dev_sel_n;                                   // R6
  assign isr_read   = rd_pulse_q & (addr_q == `HBP_ISR_ADDR);         // R7
  assign marks_full = (mark_cnt_q == `HBP_MARKS_RESET);               // R13

  // Bus style: sampled from the read strobe at every latch rise
  // A host may switch style without a reset; a deselected latch still counts
  // because the style belongs to the bus, not to this device's select
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      style_q <= `HBP_STYLE_RST;                                      // R11
    end else if (as_rise) begin
      style_q <= i_transfer_strobe;                                   // R10
    end
  end

  // Address capture on the latch fall; same edge serves both styles
  // Select qualifies it so a latch aimed at another device leaves the address
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      addr_q <= `HBP_BYTE_RST;
    end else if (as_fall && selected) begin
      addr_q <= i_muxed_bus;                                          // R5 R15
    end
  end

  // Transfer decode; a dropped select aborts without a request
  // Pulses default low on every path so a request never lasts two cycles
  // Limitation: a write cut short by a dropped select is silently lost
  always @* begin
    state_d    = state_q;
    wr_data_d  = wr_data_q;
    wr_pulse_d = 1'b0;
    rd_pulse_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (!selected) begin
          state_d = ST_IDLE;                                          // R6
        end else if (style_q == `HBP_STYLE_DIR) begin
          // Strobe rise starts the access, direction decides its kind
          if (ds_rise && i_rw_wr) begin
            state_d    = ST_RD;                                       // R1 R3
            rd_pulse_d = 1'b1;
          end else if (ds_rise) begin
            state_d   = ST_WR;                                        // R1 R3
            wr_data_d = i_muxed_bus;
          end
        end else begin
          // Separate style: both strobes active low, write wins a clash
          if (!i_rw_wr) begin
            state_d   = ST_WR;                                        // R2
            wr_data_d = i_muxed_bus;
          end else if (!i_transfer_strobe) begin
            state_d    = ST_RD;                                       // R4
            rd_pulse_d = 1'b1;
          end
        end
      end
      ST_WR: begin
        if (!selected) begin
          state_d = ST_IDLE;                                          // R6
        end else if (style_q == `HBP_STYLE_DIR ? i_transfer_strobe : !i_rw_wr) begin
          // Keep tracking the bus; the byte before the strobe ends is taken
          wr_data_d = i_muxed_bus;                                    // R3 R2
        end else begin
          state_d    = ST_IDLE;
          wr_pulse_d = 1'b1;
        end
      end
      ST_RD: begin
        // Read ends when its strobe goes away or select drops
        if (!selected) begin
          state_d = ST_IDLE;                                          // R6
        end else if (style_q == `HBP_STYLE_DIR ? !i_transfer_strobe : i_transfer_strobe) begin
          state_d = ST_IDLE;                                          // R3 R4
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Transfer registers
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_q    <= ST_IDLE;
      wr_data_q  <= `HBP_BYTE_RST;
      wr_pulse_q <= 1'b0;
      rd_pulse_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      wr_data_q  <= wr_data_d;
      wr_pulse_q <= wr_pulse_d;
      rd_pulse_q <= rd_pulse_d;
    end
  end

  // Read drive; enable follows the state so it drops with the strobe
  // The byte follows the internal source every cycle; it reaches the host
  // only once the enable rises, one cycle after the read request
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      bus_out_q <= `HBP_BYTE_RST;
      bus_oe_q  <= 1'b0;
    end else begin
      bus_oe_q  <= (state_d == ST_RD) && (state_q == ST_RD);          // R3 R4 R6
      bus_out_q <= i_rd_data;
    end
  end

  // Sticky HDLC request; a new event beats the clearing read
  // Trade-off: a read racing an event leaves the pin low, never loses one
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      irq_pend_q <= 1'b0;                                             // R12
    end else if (i_hdlc_irq) begin
      irq_pend_q <= 1'b1;                                             // R7
    end else if (isr_read) begin
      irq_pend_q <= 1'b0;                                             // R7
    end
  end

  // Shared open-drain pin: function picked by the control bit
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      irq_oe_q  <= 1'b0;
      irq_out_q <= 1'b0;
    end else begin
      irq_out_q <= 1'b0;
      if (i_irq_pin_function_select == `HBP_FUNC_NDA) begin
        irq_oe_q <= i_new_rx_data;                                    // R8 R9
      end else begin
        irq_oe_q <= irq_pend_q;                                       // R8 R7
      end
    end
  end

  // Consecutive mark counter; a space restarts it, it stops at the limit
  // Saturation keeps the reset output low on a long idle line
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      mark_cnt_q <= `HBP_MARK_CNT_RST;
    end else if (!i_te_mode) begin
      mark_cnt_q <= `HBP_MARK_CNT_RST;
    end else if (i_rx_bit_valid && !i_rx_mark) begin
      mark_cnt_q <= `HBP_MARK_CNT_RST;                                // R13
    end else if (i_rx_bit_valid && !marks_full) begin
      mark_cnt_q <= mark_cnt_q + `HBP_MARK_CNT_ONE;                   // R13
    end
  end

  // Line pin: reset output in terminal mode, star data in network mode
  // Between star slots the pin holds its last bit
  always @(posedge i_mclk) begin
    if (i_sys_rst) begin
      line_oe_q  <= 1'b0;
      line_out_q <= 1'b0;
    end else begin
      line_out_q <= 1'b0;
      if (i_te_mode) begin
        line_oe_q <= marks_full;                                      // R13
      end else if (i_star_bit_en) begin
        // A zero pulls low so several units wire-OR onto one star
        line_oe_q <= ~i_star_rx_data;                                 // R14
      end
    end
  end

  // Reset fan-out: one cycle late, held for as long as reset stands
  // No reset branch needed: the flop simply follows the reset input
  always @(posedge i_mclk) begin
    core_rst_q <= i_sys_rst;                                          // R12
  end

  // Outputs straight from flops
  // Open-drain data flops stay low; only the enables move
  assign o_muxed_bus        = bus_out_q;
  assign o_muxed_bus_oe     = bus_oe_q;
  assign o_reg_addr         = addr_q;
  assign o_wr_data          = wr_data_q;
  assign o_wr_pulse         = wr_pulse_q;
  assign o_rd_pulse         = rd_pulse_q;
  assign o_irq_nda          = irq_out_q;
  assign o_irq_nda_oe       = irq_oe_q;
  assign o_line_rst_star    = line_out_q;
  assign o_line_rst_star_oe = line_oe_q;
  assign o_bus_style        = style_q;
  assign o_core_rst         = core_rst_q;

endmodule // hbp_port

// ===== tb/hbp_port_asserts.sv
`timescale 1ns/1ps
`include "hbp_port_regs.vh"
// Watches the host port and both request pins
module hbp_port_asserts (
  // Clock, reset and strobes
  input wire logic i_mclk, i_sys_rst, i_rw_wr, i_transfer_strobe, i_addr_capture_strobe, i_dev_sel_n,
  // Pulses, pins and selects
  input wire logic o_wr_pulse, o_rd_pulse, i_irq_pin_function_select, i_new_rx_data, o_irq_nda_oe,
  input wire logic o_bus_style, o_core_rst, i_te_mode, i_rx_bit_valid, i_rx_mark, o_line_rst_star_oe,
  // Bytes
  input wire logic [`HBP_BUS_W-1:0] i_muxed_bus, o_reg_addr, o_wr_data
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  logic [7:0] mark_q; // Consecutive marks, saturating
  logic       full_q; // Count stood at the limit last cycle
  wire        isr_rd = o_rd_pulse && o_reg_addr == `HBP_ISR_ADDR; // Clearing read
  // Own mark count, so the pin is judged against the line, not the design
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      mark_q <= 8'h00;
      full_q <= 1'b0;
    end else begin
      full_q <= mark_q == 8'h80;
      if (!i_te_mode)
        mark_q <= 8'h00;
      else if (i_rx_bit_valid)
        mark_q <= !i_rx_mark ? 8'h00 : (mark_q == 8'h80) ? mark_q : mark_q + 8'h01;
    end
  end
  // Direction-style read request
  sequence dir_rd_go;
    !o_bus_style && !i_dev_sel_n && i_rw_wr && $rose(i_transfer_strobe);
  endsequence
  chk_rst_defaults: assert property ($fell(i_sys_rst) |-> !o_bus_style && !o_wr_pulse && o_core_rst)
    else $error("port not idle after reset");
  chk_style_pick: assert property ($rose(i_addr_capture_strobe) |=> o_bus_style == $past(i_transfer_strobe))
    else $error("bus style not taken at latch rise");
  chk_addr_take: assert property ($fell(i_addr_capture_strobe) && !i_dev_sel_n |=> o_reg_addr == $past(i_muxed_bus))
    else $error("address not captured at strobe fall");
  chk_sel_refuse: assert property (i_dev_sel_n |=> !o_wr_pulse && !o_rd_pulse)
    else $error("transfer while not selected");
  chk_dir_read: assert property (dir_rd_go |=> o_rd_pulse ##1 !o_rd_pulse)
    else $error("read start pulse wrong");
  chk_dir_write: assert property (o_wr_pulse && !o_bus_style |-> $past(i_transfer_strobe, 2) &&
    !$past(i_transfer_strobe) && !$past(i_rw_wr, 2) && o_wr_data == $past(i_muxed_bus, 2))
    else $error("write pulse or byte wrong");
  chk_nda_level: assert property ($past(i_irq_pin_function_select) && !$past(i_sys_rst) |->
    o_irq_nda_oe == $past(i_new_rx_data))
    else $error("new data pin wrong");
  chk_irq_clear: assert property ($fell(o_irq_nda_oe) && !$past(i_irq_pin_function_select) &&
    !$past(i_irq_pin_function_select, 2) |-> $past(isr_rd, 2))
    else $error("request dropped without status read");
  chk_line_reset: assert property (i_te_mode && $past(i_te_mode) && !$past(i_sys_rst) |-> o_line_rst_star_oe == full_q)
    else $error("line reset pin wrong");
endmodule // hbp_port_asserts
bind hbp_port hbp_port_asserts u_hbp_port_asserts (.*);

// ===== tb/hbp_host_model.sv
`timescale 1ns/1ps
// Host processor on the multiplexed bus; one byte per access
module hbp_host_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_bus,
  output logic            o_rw_wr, o_strobe, o_ale, o_sel_n, o_en,
  output logic [7:0]      o_bus
);
  logic [7:0] rd_q;  // Bus byte at the last edge the read strobe stood
  logic       rd_on; // Read strobe active
  initial {o_rw_wr, o_strobe, o_ale, o_sel_n, o_en, o_bus, rd_on} = {4'b1001, 9'h000, 1'b0};
  always @(posedge i_mclk) if (rd_on) rd_q <= i_bus;
  // Select only after the latch rise, so a style switch never looks like a strobe
  task automatic acc(input logic sep, wr, desel, input logic [7:0] a, d);
    @(posedge i_mclk);
    {o_ale, o_strobe, o_bus, o_en, o_rw_wr} <= {1'b1, sep, a, 1'b1, sep | !wr};
    @(posedge i_mclk);
    {o_ale, o_sel_n} <= {1'b0, desel};
    @(posedge i_mclk);
    {o_bus, o_en, rd_on} <= {d, wr, !wr};
    if (!sep) o_strobe <= 1'b1;
    else if (wr) o_rw_wr <= 1'b0;
    else o_strobe <= 1'b0;
    repeat (3) @(posedge i_mclk);
    {o_strobe, o_rw_wr, rd_on} <= {sep, 2'b10};
    @(posedge i_mclk);
    {o_sel_n, o_en} <= 2'b10;
    @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
endmodule // hbp_host_model

// ===== tb/test_hbp_port.sv
`timescale 1ns/1ps
`include "hbp_port_regs.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_hbp_port;
  // Bench-driven inputs
  logic i_mclk = 0, i_sys_rst = 1, i_irq_pin_function_select = 0, i_hdlc_irq = 0, i_new_rx_data = 0;
  logic i_te_mode = 1, i_rx_bit_valid = 0, i_rx_mark = 0, i_star_bit_en = 0, i_star_rx_data = 0;
  // Host lines and design outputs
  wire i_rw_wr, i_transfer_strobe, i_addr_capture_strobe, i_dev_sel_n, h_en;
  wire o_muxed_bus_oe, o_wr_pulse, o_rd_pulse, o_irq_nda, o_irq_nda_oe;
  wire o_line_rst_star, o_line_rst_star_oe, o_bus_style, o_core_rst;
  wire [7:0] i_muxed_bus, o_muxed_bus, o_reg_addr, o_wr_data, i_rd_data, h_bus;
  int miscompares = 0, compares = 0, wr_n = 0, rd_n = 0;
  logic [7:0] wr_b = 8'h00; // Last byte written
  // A released bus shows the inverse, never a stale copy
  assign i_muxed_bus = o_muxed_bus_oe ? o_muxed_bus : h_en ? h_bus : ~h_bus;
  assign i_rd_data = ~o_reg_addr;
  initial forever #10 i_mclk = ~i_mclk;
  hbp_port u_hbp_port (.*);
  hbp_host_model u_hbp_host_model (.i_mclk, .i_bus(i_muxed_bus), .o_rw_wr(i_rw_wr), .o_strobe(i_transfer_strobe),
    .o_ale(i_addr_capture_strobe), .o_sel_n(i_dev_sel_n), .o_en(h_en), .o_bus(h_bus));
  // Count pulses so missing or extra ones show
  always @(posedge i_mclk) begin
    if (o_wr_pulse) wr_n <= wr_n + 1;
    if (o_wr_pulse) wr_b <= o_wr_data;
    if (o_rd_pulse) rd_n <= rd_n + 1;
  end
  task automatic t_dir();
    u_hbp_host_model.acc(0, 1, 0, 8'h3C, 8'hA5);
    `CHK(wr_b, 8'hA5)
    `CHK(o_reg_addr, 8'h3C)
    u_hbp_host_model.acc(0, 0, 0, 8'h5A, 8'h00);
    `CHK(u_hbp_host_model.rd_q, 8'hA5)
    `CHK({wr_n, rd_n}, {32'd1, 32'd1})
    $display("t_dir done");
  endtask
  task automatic t_sep();
    u_hbp_host_model.acc(1, 1, 0, 8'h11, 8'hC3);
    `CHK(o_bus_style, 1'b1)
    `CHK(wr_b, 8'hC3)
    u_hbp_host_model.acc(1, 0, 0, 8'h22, 8'h00);
    `CHK(u_hbp_host_model.rd_q, 8'hDD)
    `CHK(o_reg_addr, 8'h22)
    u_hbp_host_model.acc(1, 1, 1, 8'h77, 8'h99);
    u_hbp_host_model.acc(1, 0, 1, 8'h66, 8'h00);
    `CHK({wr_n, rd_n, o_reg_addr}, {32'd2, 32'd2, 8'h22})
    $display("t_sep done");
  endtask
  // Reset in mid-run falls back to direction style
  task automatic t_rst();
    @(posedge i_mclk) i_sys_rst <= 1;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk) `CHK({o_bus_style, o_core_rst}, 2'b01)
    @(posedge i_mclk) i_sys_rst <= 0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) `CHK(o_core_rst, 1'b0)
    u_hbp_host_model.acc(0, 1, 0, 8'h3C, 8'h5A);
    `CHK(wr_b, 8'h5A)
    $display("t_rst done");
  endtask
  task automatic t_irq();
    @(posedge i_mclk) i_hdlc_irq <= 1;
    @(posedge i_mclk) i_hdlc_irq <= 0;
    u_hbp_host_model.acc(0, 0, 0, 8'h05, 8'h00);
    `CHK(o_irq_nda_oe, 1'b1)
    u_hbp_host_model.acc(0, 0, 0, `HBP_ISR_ADDR, 8'h00);
    `CHK(o_irq_nda_oe, 1'b0)
    // Event held across a clearing read: the set must win
    @(posedge i_mclk) i_hdlc_irq <= 1;
    u_hbp_host_model.acc(0, 0, 0, `HBP_ISR_ADDR, 8'h00);
    `CHK(o_irq_nda_oe, 1'b1)
    @(posedge i_mclk) i_hdlc_irq <= 0;
    u_hbp_host_model.acc(0, 0, 0, `HBP_ISR_ADDR, 8'h00);
    `CHK(o_irq_nda_oe, 1'b0)
    @(posedge i_mclk) {i_irq_pin_function_select, i_new_rx_data} <= 2'b11;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) `CHK({o_irq_nda, o_irq_nda_oe}, 2'b01)
    @(posedge i_mclk) i_new_rx_data <= 0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) `CHK(o_irq_nda_oe, 1'b0)
    $display("t_irq done");
  endtask
  // One mark short of the limit, then the limit, then a space
  task automatic t_line();
    @(posedge i_mclk) {i_rx_bit_valid, i_rx_mark} <= 2'b11;
    repeat (127) @(posedge i_mclk);
    i_rx_bit_valid <= 0;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk) `CHK(o_line_rst_star_oe, 1'b0)
    @(posedge i_mclk) i_rx_bit_valid <= 1;
    @(posedge i_mclk) i_rx_bit_valid <= 0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) `CHK({o_line_rst_star, o_line_rst_star_oe}, 2'b01)
    @(posedge i_mclk) {i_rx_bit_valid, i_rx_mark} <= 2'b10;
    @(posedge i_mclk) i_rx_bit_valid <= 0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) `CHK(o_line_rst_star_oe, 1'b0)
    @(posedge i_mclk) {i_te_mode, i_star_bit_en} <= 2'b01;
    @(posedge i_mclk) {i_star_bit_en, i_star_rx_data} <= 2'b01;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) `CHK(o_line_rst_star_oe, 1'b1)
    @(posedge i_mclk) i_star_bit_en <= 1;
    @(posedge i_mclk) {i_star_bit_en, i_star_rx_data} <= 2'b00;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk) `CHK(o_line_rst_star_oe, 1'b0)
    $display("t_line done");
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog, well past the roughly 280 cycles the tests need
  initial begin
    repeat (5000) @(posedge i_mclk);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 0;
    repeat (2) @(posedge i_mclk);
    @(negedge i_mclk) `CHK({o_bus_style, o_core_rst, o_muxed_bus_oe}, 3'b000)
    t_dir();
    t_sep();
    t_rst();
    t_irq();
    t_line();
    conclude();
  end
endmodule // test_hbp_port
